// ---- core/irk_regs.svh ----
// Named constants for the keypad infrared encoder: timing counts,
// register offsets and field positions.
// Assumes a 100 MHz clock that doubles as the oscillator.
`ifndef IRK_REGS_SVH
`define IRK_REGS_SVH

// Oscillator period and bit time
`define IRK_CLK_NS 10
`define IRK_BIT_NS 7680
`define IRK_BIT_CYC (`IRK_BIT_NS / `IRK_CLK_NS)
`define IRK_HALF_CYC (`IRK_BIT_CYC / 2)
`define IRK_STEP_CYC (`IRK_BIT_CYC / 8)
// Test speed-ups: scan by 3x2^3, latch readout by 3x2^7
`define IRK_STEP_FAST_CYC (`IRK_STEP_CYC / 24)
`define IRK_HALF_FAST_CYC (`IRK_HALF_CYC / 384)

// Sequence lengths in bit times or steps; the scan value is its last step index, eight steps
`define IRK_DEB_BITS 6'd16
`define IRK_SCAN_STEPS 3'd7
`define IRK_FRAME_BITS 4'd14
`define IRK_REP_LEAD 7'd62

// Carrier: one twelfth of the clock, three cycles of twelve high
`define IRK_CAR_LAST 4'hB
`define IRK_CAR_HIGH 4'h3

// Register offsets (byte addresses) and fields
`define IRK_CTRL_ADR 4'h0
`define IRK_STAT_ADR 4'h4
`define IRK_CTRL_EN 0
`define IRK_STAT_SYS 0
`define IRK_STAT_CMD 5
`define IRK_STAT_TOG 11
`define IRK_STAT_BUSY 12

`endif

// ---- core/irk_pkg.sv ----
// Types shared by the keypad infrared encoder.
// Assumes irk_regs.svh supplies the numeric constants.
package irk_pkg;

  typedef enum logic [2:0] {
    IRK_IDLE,
    IRK_DEB,
    IRK_SCAN1,
    IRK_SCAN2,
    IRK_TX,
    IRK_WAIT
  } irk_state_t;

  typedef struct packed {
    logic [7:0] ks1;
    logic [7:0] ks2;
    logic [3:0] ss1;
    logic [3:0] ss2;
    logic [3:0] pin1;
    logic [3:0] pin2;
    irk_state_t st;
    logic [9:0] cnt;
    logic [9:0] bdiv;
    logic [5:0] bits;
    logic [6:0] rep;
    logic [2:0] step;
    logic half;
    logic [13:0] sh;
    logic [4:0] sys;
    logic [5:0] cmd;
    logic tog;
    logic sent;
    logic sys_hit;
    logic key_hit;
    logic [3:0] car;
    logic dout;
    logic doe;
    logic en;
    logic ack;
    logic [31:0] dat;
  } irk_reg_t;

endpackage

// ---- core/irk_encoder.sv ----
// Keypad scanning infrared encoder: debounce, matrix scan, biphase frame
// serialiser, carrier modulation and a small Wishbone register slave.
// Assumes the matrix pins are external (synchronised here) and that the
// pad ring resolves open-drain and three-state outputs from the enables.
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "irk_regs.svh"

module irk_encoder (
  input wire logic clk_i,                  // 100 MHz oscillator clock
  input wire logic rst_i,                  // Synchronous reset, high
  input wire logic [7:0] key_sense_in_i,   // Key sense lines, low = pressed
  input wire logic [3:0] system_sense_in_i,// System sense lines
  input wire logic system_mode_select_i,   // High = single system mode
  input wire logic test_fast_scan_i,       // Test pin 1
  input wire logic test_fast_latch_read_i, // Test pin 2
  input wire logic osc_level_i,            // Oscillator pin level
  output logic [7:0] scan_drive_out_o,     // Driver level, always low
  output logic [7:0] scan_drive_oe_o,      // Driver conducting
  output logic key_pullup_en_o,            // Key sense pull-ups on
  output logic system_pullup_en_o,         // System sense pull-ups on
  output logic data_out_o,                 // Baseband biphase data
  output logic data_oe_o,                  // Baseband drive enable
  output logic modulated_data_out_o,       // Carrier-gated data
  output logic modulated_data_oe_o,        // Modulated drive enable
  input wire logic [3:0] wb_adr_i,         // Wishbone byte address
  input wire logic [31:0] wb_dat_i,        // Wishbone write data
  input wire logic [3:0] wb_sel_i,         // Wishbone byte selects
  input wire logic wb_we_i,                // Wishbone write
  input wire logic wb_cyc_i,               // Wishbone cycle
  input wire logic wb_stb_i,               // Wishbone strobe
  output logic [31:0] wb_dat_o,            // Wishbone read data
  output logic wb_ack_o                    // Wishbone acknowledge
);

  irk_pkg::irk_reg_t r;
  irk_pkg::irk_reg_t next_r;
  logic [7:0] klow;
  logic [3:0] slow;
  logic [3:0] slow_any;
  logic single;
  logic held;
  logic [4:0] hits;
  logic init;
  logic [9:0] step_len;
  logic [9:0] half_len;
  logic step_tick;
  logic half_tick;
  logic bit_tick;
  logic [2:0] kidx;
  logic [1:0] sidx;

  // Index of the lowest active line; callers only use it with one line low
  function automatic logic [2:0] low_idx8(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // Synchronised pin views; only the second stage is ever read
  assign single = r.pin2[0];
  assign klow = ~r.ks2;
  assign slow_any = ~r.ss2;
  assign slow = single ? 4'h0 : slow_any;
  assign hits = 5'($countones(klow)) + 5'($countones(slow));
  assign held = (hits != 5'h0);
  assign init = r.pin2[1] & r.pin2[2] & r.pin2[3];
  assign kidx = low_idx8(klow);
  assign sidx = 2'(low_idx8({4'h0, slow_any}));

  // Unit lengths; test pins shorten scan steps and bit halves
  assign step_len = r.pin2[1] ? 10'(`IRK_STEP_FAST_CYC) : 10'(`IRK_STEP_CYC);
  assign half_len = r.pin2[2] ? 10'(`IRK_HALF_FAST_CYC) : 10'(`IRK_HALF_CYC);
  assign step_tick = (r.cnt == step_len - 10'h1);
  assign half_tick = (r.cnt == half_len - 10'h1);
  assign bit_tick = (r.bdiv == 10'(`IRK_BIT_CYC) - 10'h1);

  // Next-state logic for the whole block
  always_comb begin
    next_r = r;
    next_r.ks1 = key_sense_in_i;
    next_r.ks2 = r.ks1;
    next_r.ss1 = system_sense_in_i;
    next_r.ss2 = r.ss1;
    next_r.pin1 = {osc_level_i, test_fast_latch_read_i, test_fast_scan_i, system_mode_select_i};
    next_r.pin2 = r.pin1;
    next_r.cnt = r.cnt + 10'h1;
    next_r.car = (r.car == `IRK_CAR_LAST) ? 4'h0 : r.car + 4'h1;

    // Repetition clock runs from frame start so the period is fixed
    if (r.st == irk_pkg::IRK_TX || r.st == irk_pkg::IRK_WAIT || r.st == irk_pkg::IRK_SCAN1 ||
        r.st == irk_pkg::IRK_SCAN2) begin
      next_r.bdiv = bit_tick ? 10'h0 : r.bdiv + 10'h1;
      if (bit_tick) begin
        next_r.rep = r.rep + 7'h1;
      end
    end

    case (r.st)
      irk_pkg::IRK_IDLE: begin
        next_r.cnt = 10'h0;
        // Exactly one active key line, or system line outside single system mode, starts debounce; more is ignored
        if (r.en && hits == 5'h1) begin
          next_r.st = irk_pkg::IRK_DEB;
          next_r.bits = 6'h0;
        end
      end
      irk_pkg::IRK_DEB: begin
        // Drivers keep conducting so that a bounce shows as a release
        if (!held) begin
          next_r.st = irk_pkg::IRK_IDLE;
        end else if (r.cnt == 10'(`IRK_BIT_CYC) - 10'h1) begin
          next_r.cnt = 10'h0;
          next_r.bits = r.bits + 6'h1;
          if (r.bits == `IRK_DEB_BITS - 6'h1) begin
            next_r.st = irk_pkg::IRK_SCAN1;
            next_r.step = 3'h0;
            next_r.sys_hit = 1'b0;
            next_r.key_hit = 1'b0;
            next_r.rep = 7'h0;
            next_r.bdiv = 10'h0;
          end
        end
      end
      irk_pkg::IRK_SCAN1, irk_pkg::IRK_SCAN2: begin
        if (step_tick) begin
          next_r.cnt = 10'h0;
          next_r.step = r.step + 3'h1;
          // Sample at the end of each step; later steps overwrite earlier
          if (single && r.st == irk_pkg::IRK_SCAN1) begin
            if (slow_any != 4'h0) begin
              next_r.sys = {sidx, r.step};
              next_r.sys_hit = 1'b1;
            end
          end else if (klow != 8'h0) begin
            next_r.cmd = {kidx, r.step};
            next_r.key_hit = 1'b1;
          end else if (slow != 4'h0) begin
            next_r.sys = {sidx, r.step};
            next_r.sys_hit = 1'b1;
          end
          if (r.step == `IRK_SCAN_STEPS) begin
            next_r.step = 3'h0;
            if (r.st == irk_pkg::IRK_SCAN1) begin
              next_r.st = irk_pkg::IRK_SCAN2;
            end else if (!r.key_hit && !r.sys_hit && klow == 8'h0 && slow == 4'h0) begin
              next_r.st = irk_pkg::IRK_IDLE;
            end else if (single && !r.sys_hit) begin
              next_r.st = irk_pkg::IRK_IDLE;
            end else if (single && !r.key_hit && klow == 8'h0) begin
              next_r.st = irk_pkg::IRK_IDLE;
            end else begin
              // Frame: two start ones, control, system, command
              next_r.st = irk_pkg::IRK_TX;
              next_r.sh[13:12] = 2'b11;
              next_r.sh[11] = r.tog;
              next_r.sh[10:6] = next_r.sys;
              next_r.sh[5:0] = (next_r.key_hit && !single) || single ? next_r.cmd : 6'h3F;
              if (!single && !next_r.key_hit) begin
                next_r.sh[5:0] = 6'h3F;
                next_r.cmd = 6'h3F;
              end
              next_r.bits = 6'h0;
              next_r.half = 1'b0;
              next_r.rep = 7'h0;
              next_r.bdiv = 10'h0;
            end
          end
        end
      end
      irk_pkg::IRK_TX: begin
        // The frame always runs to its end, key or no key
        if (half_tick) begin
          next_r.cnt = 10'h0;
          next_r.half = ~r.half;
          if (r.half) begin
            next_r.sh = {r.sh[12:0], 1'b0};
            next_r.bits = r.bits + 6'h1;
            if (r.bits[3:0] == `IRK_FRAME_BITS - 4'h1) begin
              next_r.st = irk_pkg::IRK_WAIT;
              next_r.sent = 1'b1;
            end
          end
        end
      end
      irk_pkg::IRK_WAIT: begin
        next_r.cnt = 10'h0;
        if (!held) begin
          // Release between frames ends the burst and marks a new key
          next_r.st = irk_pkg::IRK_IDLE;
          if (r.sent) begin
            next_r.tog = ~r.tog;
            next_r.sent = 1'b0;
          end
        end else if (next_r.rep == `IRK_REP_LEAD) begin
          // Leave on the tick itself; a cycle late would stretch every period
          next_r.st = irk_pkg::IRK_SCAN1;
          next_r.step = 3'h0;
          next_r.sys_hit = 1'b0;
          next_r.key_hit = 1'b0;
        end
      end
      default: begin
        next_r.st = irk_pkg::IRK_IDLE;
      end
    endcase

    // Biphase: first half inverted, second half true; data rests low off-frame
    // so the carrier never toggles behind a floating pin
    next_r.doe = (next_r.st == irk_pkg::IRK_TX);
    next_r.dout = next_r.doe & (next_r.half ? next_r.sh[13] : ~next_r.sh[13]);

    // Test initialisation keeps the system and command latches
    if (init) begin
      next_r.st = irk_pkg::IRK_IDLE;
      next_r.cnt = 10'h0;
      next_r.bits = 6'h0;
      next_r.rep = 7'h0;
      next_r.bdiv = 10'h0;
      next_r.step = 3'h0;
      next_r.half = 1'b0;
      next_r.sh = 14'h0;
      next_r.tog = 1'b0;
      next_r.sent = 1'b0;
      next_r.sys_hit = 1'b0;
      next_r.key_hit = 1'b0;
      next_r.doe = 1'b0;
      next_r.dout = 1'b0;
    end

    // Wishbone slave: one wait state, unmapped reads give zero
    next_r.ack = wb_cyc_i & wb_stb_i & ~r.ack;
    next_r.dat = 32'h0;
    if (wb_cyc_i && wb_stb_i && !r.ack) begin
      if (wb_we_i && wb_adr_i == `IRK_CTRL_ADR && wb_sel_i[0]) begin
        next_r.en = wb_dat_i[`IRK_CTRL_EN];
      end
      if (!wb_we_i && wb_adr_i == `IRK_CTRL_ADR) begin
        next_r.dat[`IRK_CTRL_EN] = r.en;
      end
      if (!wb_we_i && wb_adr_i == `IRK_STAT_ADR) begin
        next_r.dat[`IRK_STAT_SYS +: 5] = r.sys;
        next_r.dat[`IRK_STAT_CMD +: 6] = r.cmd;
        next_r.dat[`IRK_STAT_TOG] = r.tog;
        next_r.dat[`IRK_STAT_BUSY] = (r.st != irk_pkg::IRK_IDLE);
      end
    end
  end

  // State register; the block comes up enabled and quiescent
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.ks1 <= 8'hFF;
      r.ks2 <= 8'hFF;
      r.ss1 <= 4'hF;
      r.ss2 <= 4'hF;
      r.st <= irk_pkg::IRK_IDLE;
      r.en <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Drivers conduct except during scan, where one at a time is on
  always_comb begin
    scan_drive_oe_o = 8'hFF;
    if (r.st == irk_pkg::IRK_SCAN1 || r.st == irk_pkg::IRK_SCAN2) begin
      scan_drive_oe_o = 8'h01 << r.step;
      if (single && r.st == irk_pkg::IRK_SCAN1) begin
        scan_drive_oe_o = 8'h01 << r.step;
      end
    end
  end

  assign scan_drive_out_o = 8'h00;
  assign key_pullup_en_o = ~(single && r.st == irk_pkg::IRK_SCAN1);
  assign system_pullup_en_o = ~single | (r.st == irk_pkg::IRK_SCAN1);
  assign data_out_o = r.dout;
  assign data_oe_o = r.doe;
  assign modulated_data_out_o = r.dout & (r.car < `IRK_CAR_HIGH);
  assign modulated_data_oe_o = r.doe;
  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.dat;

endmodule
`default_nettype wire

// ---- test/irk_keypad_model.sv ----
// Keypad matrix model: a closed contact pulls its sense line low
// while its driver conducts. Assumes one key and one system contact.
`timescale 1ns/100ps
`default_nettype none
module irk_keypad_model (
  input wire logic clk_i, // Clock
  input wire logic [7:0] scan_drive_oe_i, // Drivers on
  input wire logic key_pullup_en_i, // Key pull-ups
  input wire logic system_pullup_en_i, // System pull-ups
  input wire logic key_down_i, // Key closed
  input wire logic [2:0] key_line_i, // Key line
  input wire logic [2:0] key_drv_i, // Key driver
  input wire logic sys_down_i, // System closed
  input wire logic [1:0] sys_line_i, // System line
  input wire logic [2:0] sys_drv_i, // System driver
  output logic [7:0] key_sense_o, // Key sense
  output logic [3:0] system_sense_o // System sense
);
  logic wander = 1'b0;
  // A line with no pull-up wanders, so a stale level is never read as data
  always @(posedge clk_i) wander <= ~wander;
  // Pull-up or float first; a closed contact on a live driver wins
  always_comb begin
    key_sense_o = key_pullup_en_i ? 8'hFF : {8{wander}};
    system_sense_o = system_pullup_en_i ? 4'hF : {4{wander}};
    if (key_down_i && scan_drive_oe_i[key_drv_i]) key_sense_o[key_line_i] = 1'b0;
    if (sys_down_i && scan_drive_oe_i[sys_drv_i]) system_sense_o[sys_line_i] = 1'b0;
  end
endmodule
`default_nettype wire

// ---- test/irk_encoder_asserts.sv ----
// Pin checks of the encoder: drivers, frame, carrier and pull-ups.
// Assumes a bind to irk_encoder, one clock and a high reset.
`timescale 1ns/100ps
`default_nettype none
module irk_encoder_asserts (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic system_mode_select_i, // Mode pin
  input wire logic [7:0] scan_drive_oe_o, // Drivers on
  input wire logic key_pullup_en_o, // Key pull-ups
  input wire logic system_pullup_en_o, // System pull-ups
  input wire logic data_out_o, // Data
  input wire logic data_oe_o, // Data enable
  input wire logic modulated_data_out_o, // Modulated data
  input wire logic modulated_data_oe_o // Modulated enable
);
  logic [15:0] oe_run;
  logic [7:0] oe_prev;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Enable run length, read as the frame ends; last driver pattern
  always_ff @(posedge clk_i) begin
    oe_run <= (rst_i || !data_oe_o) ? 16'h0000 : oe_run + 16'h0001;
    oe_prev <= scan_drive_oe_o;
  end
  // Carrier burst starts with data high; a fast data change may cut it short
  sequence car_on_s;
    $rose(modulated_data_out_o) && $past(data_out_o);
  endsequence
  sequence car_rest_s;
    (modulated_data_out_o || !data_out_o) [*2] ##1 (!modulated_data_out_o || !data_out_o);
  endsequence
  quiet_reset_a: assert property ($fell(rst_i) |-> scan_drive_oe_o == 8'hFF && !data_oe_o)
    else $error("outputs not quiet after reset");
  drv_single_a: assert property (scan_drive_oe_o != 8'hFF |-> $onehot0(scan_drive_oe_o))
    else $error("several drivers in scan");
  scan_order_a: assert property ($onehot(scan_drive_oe_o) && $onehot(oe_prev) && scan_drive_oe_o != oe_prev
    |-> scan_drive_oe_o == {oe_prev[6:0], oe_prev[7]})
    else $error("driver out of order");
  float_quiet_a: assert property (!data_oe_o |-> !modulated_data_oe_o && !modulated_data_out_o)
    else $error("modulated pin driven idle");
  mod_gate_a: assert property (modulated_data_out_o |-> data_out_o && modulated_data_oe_o)
    else $error("carrier without data");
  car_duty_a: assert property (car_on_s |-> ##1 car_rest_s)
    else $error("carrier duty wrong");
  frame_len_a: assert property ($fell(data_oe_o) |-> oe_run == 16'h001C || oe_run == 16'h2A00)
    else $error("frame length wrong");
  start_low_a: assert property ($rose(data_oe_o) |-> !data_out_o)
    else $error("start bit first half high");
  pullup_excl_a: assert property (system_mode_select_i [*4] |-> !(key_pullup_en_o && system_pullup_en_o))
    else $error("both pull-ups on");
endmodule
bind irk_encoder irk_encoder_asserts irk_encoder_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
  .system_mode_select_i(system_mode_select_i), .scan_drive_oe_o(scan_drive_oe_o),
  .key_pullup_en_o(key_pullup_en_o), .system_pullup_en_o(system_pullup_en_o), .data_out_o(data_out_o),
  .data_oe_o(data_oe_o), .modulated_data_out_o(modulated_data_out_o), .modulated_data_oe_o(modulated_data_oe_o));
`default_nettype wire

// ---- test/ir_remote_keypad_encoder_test.sv ----
// Bench: matrix presses drive the encoder; frames read off the data pin
// are compared with a reference model. Test pins high for fast frames.
`timescale 1ns/100ps
`default_nettype none
`include "irk_regs.svh"
module ir_remote_keypad_encoder_test;
  logic clk_i = 1'b0, rst_i = 1'b1, kd = 1'b0, sd = 1'b0, cyc_i = 1'b0, we_i = 1'b0, m_tog = 1'b0;
  logic system_mode_select = 1'b0, osc = 1'b0;
  logic [2:0] kl = 3'h0, kdrv = 3'h0, sdrv = 3'h2;
  logic [1:0] sl = 2'h1;
  logic [3:0] adr_i = 4'h0, sel_i = 4'hF, ss;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [7:0] ks, oe, sdo;
  logic kpu, spu, dout, doe, mout, moe, ack;
  logic [4:0] m_sys;
  logic [5:0] m_cmd;
  int error_cnt = 0, comparisons = 0, cyc = 0, f_start, seed = 32'hDF876248;
  irk_encoder irk_encoder_i (.clk_i(clk_i), .rst_i(rst_i), .key_sense_in_i(ks), .system_sense_in_i(ss),
    .system_mode_select_i(system_mode_select), .test_fast_scan_i(1'b1), .test_fast_latch_read_i(1'b1), .osc_level_i(osc),
    .scan_drive_out_o(sdo), .scan_drive_oe_o(oe), .key_pullup_en_o(kpu), .system_pullup_en_o(spu),
    .data_out_o(dout), .data_oe_o(doe), .modulated_data_out_o(mout), .modulated_data_oe_o(moe),
    .wb_adr_i(adr_i), .wb_dat_i(dat_i), .wb_sel_i(sel_i), .wb_we_i(we_i), .wb_cyc_i(cyc_i),
    .wb_stb_i(cyc_i), .wb_dat_o(dat_o), .wb_ack_o(ack));
  irk_keypad_model irk_keypad_model_i (.clk_i(clk_i), .scan_drive_oe_i(oe), .key_pullup_en_i(kpu),
    .system_pullup_en_i(spu), .key_down_i(kd), .key_line_i(kl), .key_drv_i(kdrv), .sys_down_i(sd),
    .sys_line_i(sl), .sys_drv_i(sdrv), .key_sense_o(ks), .system_sense_o(ss));
  // Clock and a cycle count for frame spacing
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  task automatic give_verdict();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // A wait that ran out ends the run at once
  task automatic bound(input int n);
    if (n >= 60000) begin
      check(32'h0, 32'h1, "wait bound");
      give_verdict();
    end
  endtask
  // Classic single cycle; request held until ack is seen at an edge
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    adr_i <= a;
    we_i <= w;
    sel_i <= w ? 4'h1 : 4'hF;
    dat_i <= d;
    cyc_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 60000);
    bound(n);
    q = dat_o;
    cyc_i <= 1'b0;
  endtask
  // Reads one frame, each bit as two one-cycle halves
  task automatic frame(input logic [13:0] e);
    int n;
    logic [13:0] got;
    n = 0;
    while (doe !== 1'b1 && n < 60000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    bound(n);
    f_start = cyc;
    for (int b = 13; b >= 0; b--) begin
      check(dout, !e[b], "first half");
      @(posedge clk_i);
      #1;
      got[b] = dout;
      check(dout, e[b], "second half");
      @(posedge clk_i);
      #1;
    end
    check(got, e, "frame bits");
    check(doe, 0, "frame end");
  endtask
  // Main sequence
  initial begin
    logic [31:0] q, r;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    check(oe, 8'hFF, "drivers idle");
    check(sdo, 8'h00, "driver level");
    check({doe, moe, kpu, spu}, 4'h3, "outputs idle");
    wb(4'h0, 1'b0, 32'h0, q);
    check(q, 32'h1, "ctrl reset");
    wb(4'h8, 1'b1, 32'hFFFFFFFF, q);
    wb(4'h8, 1'b0, 32'h0, q);
    check(q, 32'h0, "unmapped read");
    // Enable bit writes back and reads back, then is restored
    wb(4'h0, 1'b1, 32'h0, q);
    wb(4'h0, 1'b0, 32'h0, q);
    check(q, 32'h0, "ctrl cleared");
    wb(4'h0, 1'b1, 32'h1, q);
    // Key and system contact together stay ignored
    @(posedge clk_i);
    kd <= 1'b1;
    sd <= 1'b1;
    r = 0;
    repeat (400) begin
      @(posedge clk_i);
      r[0] = r[0] | (oe !== 8'hFF) | doe;
    end
    check(r, 0, "two lines idle");
    // A wrongly started debounce shows as busy long before any scan
    wb(4'h4, 1'b0, 32'h0, q);
    check(q[12], 1'b0, "busy two lines");
    // System contact alone sends the all-ones command
    @(posedge clk_i);
    kd <= 1'b0;
    m_sys = {sl, sdrv};
    m_cmd = 6'h3F;
    frame({2'b11, m_tog, m_sys, m_cmd});
    @(posedge clk_i);
    sd <= 1'b0;
    m_tog = ~m_tog;
    repeat (20) @(posedge clk_i);
    #1;
    check(oe, 8'hFF, "drivers after release");
    wb(4'h4, 1'b0, 32'h0, q);
    check(q, {19'h0, 1'b0, m_tog, m_cmd, m_sys}, "status");
    // Random key, held for a repeat, keeps the system latch
    r = $random(seed);
    @(posedge clk_i);
    kl <= r[2:0];
    kdrv <= r[5:3];
    kd <= 1'b1;
    m_cmd = {r[2:0], r[5:3]};
    frame({2'b11, m_tog, m_sys, m_cmd});
    q = f_start;
    frame({2'b11, m_tog, m_sys, m_cmd});
    // Sixty-four bit times, less what the fast scan pin saves on two scans
    check(f_start - q, 64 * `IRK_BIT_CYC - 16 * (`IRK_STEP_CYC - `IRK_STEP_FAST_CYC), "repeat period");
    @(posedge clk_i);
    kd <= 1'b0;
    repeat (20) @(posedge clk_i);
    #1;
    check(oe, 8'hFF, "drivers after key");
    m_tog = ~m_tog;
    // Single system mode: wired system contact read by scan one, key by scan two
    @(posedge clk_i);
    system_mode_select <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    check({kpu, spu}, 2'b10, "single pull-ups");
    r = $random(seed);
    @(posedge clk_i);
    kl <= r[2:0];
    kdrv <= r[5:3];
    sl <= r[7:6];
    sdrv <= r[10:8];
    kd <= 1'b1;
    sd <= 1'b1;
    m_sys = {r[7:6], r[10:8]};
    m_cmd = {r[2:0], r[5:3]};
    frame({2'b11, m_tog, m_sys, m_cmd});
    @(posedge clk_i);
    kd <= 1'b0;
    sd <= 1'b0;
    repeat (20) @(posedge clk_i);
    // Test initialisation clears the toggle bit but keeps both latches
    osc <= 1'b1;
    repeat (4) @(posedge clk_i);
    osc <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(4'h4, 1'b0, 32'h0, q);
    check(q, {19'h0, 1'b0, 1'b0, m_cmd, m_sys}, "status after init");
    give_verdict();
  end
endmodule
`default_nettype wire
